//--- pol_protection_manager_tb.sv
// Purpose: Self-checking bench for the protection manager.
// Assumes: Restart interval shortened to 50 cycles.
// Notes: Inputs change on falling edges only, so no race with the design.
`include "ppm_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pol_protection_manager_tb;
  logic clk_in = 0, nrst_in = 0, wr = 0, il = 0, st = 0, en = 0, ext = 0;
  logic [1:0] ad = 2'h0;
  logic [7:0] wd = 8'h00, tp = 8'h19;
  logic [15:0] vo = 16'h03E8, vs = 16'h03E8, vp = 16'h0000;
  wire pin, oe, on, fo, tc, tw, pw, te;
  wire [2:0] ls;
  wire [7:0] rd;
  wire [3:0] cl;
  wire [6:0] ov;
  integer num_errors = 0, checks_done = 0, cyc = 0, i;
  ppm_manager #(.RETRY_CYCLES(50)) uut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(ad),
    .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd), .vout_in(vo), .vset_in(vs),
    .vprebias_in(vp), .temp_in(tp), .ilimit_in(il), .steady_in(st), .enable_cmd_in(en),
    .power_good_pin_pin_in(pin), .power_good_pin_oe_out(oe), .power_good_pin_o_out(), .conv_on_out(on),
    .fast_off_out(fo), .cl_code_out(cl), .temp_comp_out(tc), .load_slope_out(ls),
    .ov_pct_out(ov), .track_en_out(te), .temp_warn_out(tw), .pg_warn_out(pw));
  ppm_pg_wire pg (.oe_in(oe), .ext_low_in(ext), .pin_out(pin));
  initial forever #2 clk_in = ~clk_in;
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000) begin num_errors++; wrap_up; end
  end
  task wrap_up;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task n(input integer k);
    repeat (k) @(negedge clk_in);
  endtask
  task w(input [1:0] a, input [7:0] d);
    @(negedge clk_in); ad = a; wd = d; wr = 1;
    @(negedge clk_in); wr = 0;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task rc(input [1:0] a, input [7:0] m, input [7:0] e);
    @(negedge clk_in); ad = a;
    @(negedge clk_in); `CHK("rdata", e, rd & m)
  endtask
  task wt(input e);
    i = 0;
    while (on !== e && i < 80) begin @(negedge clk_in); i++; end
    `CHK("conv_on", e, on)
  endtask
  initial
  begin
    n(4);
    nrst_in = 1;
    rc(0, 8'hFF, `PPM_RST_LIMIT);
    rc(1, 8'hFF, `PPM_RST_LEVEL);
    rc(2, 8'hFF, `PPM_RST_TYPE);
    `CHK("track_en", 1'b0, te)
    rc(3, 8'h8C, 8'h8C);
    w(0, 8'h0F);
    `CHK("cl_code", 4'hB, cl)
    `CHK("temp_comp", 1'b0, tc)
    rc(0, 8'hFF, 8'h0F);
    w(0, 8'hBA);
    `CHK("cl_code", 4'hA, cl)
    `CHK("load_slope", 3'h5, ls)
    `CHK("temp_comp", 1'b1, tc)
    for (i = 0; i < 4; i++) begin
      w(1, 8'(i * 4));
      `CHK("ov_pct", i == 0 ? 7'h6E : i == 1 ? 7'h78 : 7'h82, ov)
    end
    w(1, 8'hFF);
    rc(1, 8'hFF, 8'h1F);
    w(1, 8'h08);
    // Power-good window and warnings while running.
    en = 1; wt(1); st = 1; n(3);
    `CHK("pg_oe", 1'b0, oe)
    vo = 16'h047E; n(3);
    `CHK("pg_oe", 1'b1, oe)
    `CHK("conv_on", 1'b1, on)
    vo = 16'h03A2; n(3);
    `CHK("pg_warn", 1'b0, pw)
    w(1, 8'h18); n(2);
    `CHK("pg_warn", 1'b1, pw)
    rc(3, 8'h40, 8'h00);
    w(1, 8'h08); vo = 16'h03E8; ext = 1; n(3);
    `CHK("pg_warn", 1'b1, pw)
    ext = 0; st = 0; n(3);
    `CHK("pg_oe", 1'b1, oe)
    st = 1; tp = 8'h79; n(3);
    rc(3, 8'h80, 8'h00);
    tp = 8'h76; n(3);
    `CHK("temp_warn", 1'b1, tw)
    tp = 8'h74; n(3);
    `CHK("temp_warn", 1'b0, tw)
    `CHK("conv_on", 1'b1, on)
    // Overcurrent is blind below pre-bias, then trips and retries.
    st = 0; vp = 16'h0320; vo = 16'h02BC; il = 1; n(3);
    `CHK("conv_on", 1'b1, on)
    vp = 16'h0000; n(2);
    `CHK("fast_off", 1'b1, fo)
    rc(3, 8'h08, 8'h00);
    `CHK("conv_on", 1'b0, on)
    il = 0; vo = 16'h03E8; n(30);
    `CHK("conv_on", 1'b0, on)
    wt(1);
    // Latched undervoltage stays off until its flag is cleared.
    w(3, 8'h0C); w(2, 8'hC5); st = 1; vo = 16'h02BC; n(3);
    `CHK("fast_off", 1'b0, fo)
    `CHK("track_en", 1'b1, te)
    rc(3, 8'h04, 8'h00);
    vo = 16'h03E8; n(80);
    `CHK("conv_on", 1'b0, on)
    w(3, 8'h0C);
    wt(1);
    wrap_up;
  end
endmodule
`default_nettype wire

//--- ppm_chk_assertions.sv
// Purpose: Port checks for the protection manager.
// Assumes: Flags and run request settle one edge after their cause.
// Notes: 75 percent is the lowest undervoltage level, so it is a safe trip line.
`include "ppm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ppm_chk #(parameter integer VW = 16) (
  input wire logic clk_in, // Clock.
  input wire logic nrst_in, // Reset, active low.
  input wire logic [1:0] reg_addr_in, // Register index.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic [7:0] reg_wdata_in, // Write data.
  input wire logic [VW-1:0] vout_in, // Output voltage.
  input wire logic [VW-1:0] vset_in, // Setpoint.
  input wire logic [VW-1:0] vprebias_in, // Pre-bias voltage.
  input wire logic [7:0] temp_in, // Temperature.
  input wire logic ilimit_in, // Limit reached.
  input wire logic steady_in, // Steady state.
  input wire logic power_good_pin_pin_in, // Sensed pin.
  input wire logic enable_cmd_in, // Turn-on command.
  input wire logic power_good_pin_oe_out, // Pin pulled low.
  input wire logic conv_on_out, // Run request.
  input wire logic fast_off_out, // Fast turn-off.
  input wire logic [3:0] cl_code_out, // Limit code.
  input wire logic [6:0] ov_pct_out, // Overvoltage percent.
  input wire logic temp_warn_out, // Temperature warning.
  input wire logic pg_warn_out // Power-good warning.
);
  // Percent products, wide enough that no term wraps.
  wire [31:0] vo = vout_in * 32'h64;
  wire [31:0] lo = vset_in * 32'h4B;
  wire [31:0] hi = vset_in * 32'h6E;
  wire wcl = reg_wr_in && reg_addr_in == `PPM_ADDR_LIMIT;
  wire wlv = reg_wr_in && reg_addr_in == `PPM_ADDR_LEVEL;
  wire [3:0] wcode = reg_wdata_in[3:0];
  wire [1:0] wov = reg_wdata_in[3:2];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_cl_sat: assert property (wcl |=> cl_code_out ==
    ($past(wcode) > `PPM_CL_MAX ? `PPM_CL_MAX : $past(wcode))) else $error("cl code");
  a_ov_code: assert property (wlv |=> ov_pct_out ==
    ($past(wov) == 2'h0 ? 7'h6E : $past(wov) == 2'h1 ? 7'h78 : 7'h82)) else $error("ov pct");
  a_warn_on: assert property (temp_in > `PPM_TEMP_WARN_ON |=> temp_warn_out)
    else $error("temp warn on");
  a_warn_hold: assert property (temp_warn_out && temp_in >= `PPM_TEMP_WARN_OFF
    |=> temp_warn_out) else $error("temp warn hold");
  a_oc_off: assert property (conv_on_out && ilimit_in && vout_in > vprebias_in
    && vo < lo |=> !conv_on_out && fast_off_out) else $error("oc off");
  a_uv_off: assert property (conv_on_out && steady_in && !ilimit_in && vo < lo
    |=> !conv_on_out && !fast_off_out) else $error("uv off");
  a_pg_trans: assert property (!steady_in |=> power_good_pin_oe_out)
    else $error("pg transition");
  a_pg_high: assert property (steady_in && vo > hi |=> power_good_pin_oe_out)
    else $error("pg high");
  a_pg_ext: assert property (!power_good_pin_pin_in && !power_good_pin_oe_out |=> pg_warn_out)
    else $error("pg external");
  a_off_hold: assert property ($fell(conv_on_out) && $past(enable_cmd_in)
    |=> !conv_on_out [*8])
    else $error("off hold");
  // Main scenarios reached.
  cover property (conv_on_out && ilimit_in && vo < lo);
  cover property ($rose(temp_warn_out));
  cover property ($fell(power_good_pin_oe_out));
endmodule
bind ppm_manager ppm_chk #(.VW(VW)) u_chk (.*);
`default_nettype wire

//--- ppm_manager.v
// Purpose: Protection and fault manager of a point-of-load converter.
// Assumes: Measurements arrive as synchronous digital values from converters.
// Notes: Voltages are in setpoint-relative units; thresholds are percent products.
`include "ppm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ppm_manager #(
  parameter integer VW = 16,
  parameter integer RETRY_CYCLES = `PPM_RETRY_MS * 1000 * `PPM_CLK_MHZ
)(
  input wire clk_in, // System clock.
  input wire nrst_in, // Synchronous reset, active low.
  input wire [1:0] reg_addr_in, // Register index.
  input wire reg_wr_in, // Register write strobe.
  input wire [7:0] reg_wdata_in, // Write data.
  output reg [7:0] reg_rdata_out, // Read data, registered.
  input wire [VW-1:0] vout_in, // Measured output voltage.
  input wire [VW-1:0] vset_in, // Live output setpoint.
  input wire [VW-1:0] vprebias_in, // Pre-bias voltage at start-up.
  input wire [7:0] temp_in, // Controller temperature in degrees C.
  input wire ilimit_in, // Current limit reached.
  input wire steady_in, // Output at steady state.
  input wire enable_cmd_in, // Turn-on command level.
  input wire power_good_pin_pin_in, // Sensed level of the power-good pin.
  output reg power_good_pin_oe_out, // Pulls the power-good pin low when high.
  output wire power_good_pin_o_out, // Driven pin level, always low.
  output reg conv_on_out, // Converter run request, a level; the ramp is left to tracking.
  output reg fast_off_out, // Both switches off at once.
  output reg [3:0] cl_code_out, // Saturated current-limit code.
  output reg temp_comp_out, // Temperature compensation enable.
  output reg [2:0] load_slope_out, // Load regulation slope code.
  output reg [6:0] ov_pct_out, // Overvoltage percent of setpoint.
  output reg track_en_out, // Tracking fault enabled.
  output reg temp_warn_out, // Temperature warning to power manager.
  output reg pg_warn_out // Power-good warning to power manager.
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_RETRY = 2'h1;
  localparam [1:0] ST_LATCH = 2'h2;
  localparam [31:0] RETRY_N = RETRY_CYCLES;

  // True when a write strobe is aimed at the given register index.
  function wr_hit;
    input wr;
    input [1:0] addr;
    input [1:0] target;
    begin
      wr_hit = wr & (addr == target);
    end
  endfunction

  // Percent product of a voltage. Both operands are widened first, so the
  // product cannot wrap and no divider is needed to compare with a threshold.
  function [VW+6:0] pct_scale;
    input [VW-1:0] volts;
    input [6:0] pct;
    begin
      pct_scale = {7'h00, volts} * {{VW{1'b0}}, pct};
    end
  endfunction

  // Current-limit code; anything above the top code is held at the top code.
  function [3:0] cl_sat;
    input [3:0] code;
    begin
      if (code > `PPM_CL_MAX)
        cl_sat = `PPM_CL_MAX;
      else
        cl_sat = code;
    end
  endfunction

  // Undervoltage level select to percent of setpoint.
  function [6:0] uv_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: uv_decode = 7'h4B;
        2'h1: uv_decode = 7'h50;
        2'h2: uv_decode = 7'h55;
        default: uv_decode = 7'h5A;
      endcase
    end
  endfunction

  // Overvoltage level select; the two top codes both mean the highest level.
  function [6:0] ov_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ov_decode = 7'h6E;
        2'h1: ov_decode = 7'h78;
        default: ov_decode = 7'h82;
      endcase
    end
  endfunction

  reg [7:0] limit_cfg_reg;
  reg [7:0] level_cfg_reg;
  reg [7:0] type_cfg_reg;
  reg overcur_flag_reg;
  reg underv_flag_reg;
  reg [1:0] state_reg;
  reg [31:0] tmr_reg;
  reg en_d_reg;
  reg [6:0] uv_pct;
  reg [6:0] pg_lo_pct;
  wire [VW+6:0] v100;
  wire [VW+6:0] uv_lvl;
  wire [VW+6:0] pg_lo_lvl;
  wire [VW+6:0] pg_hi_lvl;
  wire uv_low;
  wire oc_armed;
  wire oc_ev;
  wire uv_ev;
  wire pg_bad;
  wire fault_ev;
  wire fault_latch;
  wire cond_gone;
  wire tmr_done;
  wire st_wr;
  wire tmr_clear;
  wire latch_release;
  wire pg_blank;
  wire pg_window_bad;
  wire pg_ext_low;
  wire [7:0] status_byte;
  reg recycled_reg;

  assign power_good_pin_o_out = 1'b0;

  // Decode of the undervoltage and overvoltage selects. [RULE_19] [RULE_20]
  always @*
  begin
    uv_pct = uv_decode(level_cfg_reg[1:0]);
    ov_pct_out = ov_decode(level_cfg_reg[3:2]);
    pg_lo_pct = level_cfg_reg[`PPM_BIT_GOOD_LOW] ? 7'h5F : 7'h5A; // [RULE_09]
  end

  // Scaling by 100 avoids a divider; thresholds track the setpoint live. [RULE_01]
  assign v100 = pct_scale(vout_in, 7'h64);
  assign uv_lvl = pct_scale(vset_in, uv_pct);
  assign pg_lo_lvl = pct_scale(vset_in, pg_lo_pct);
  assign pg_hi_lvl = pct_scale(vset_in, 7'h6E);
  assign uv_low = v100 < uv_lvl;
  assign oc_armed = vout_in > vprebias_in; // [RULE_14]
  assign oc_ev = conv_on_out & oc_armed & ilimit_in & uv_low; // [RULE_15]
  assign uv_ev = conv_on_out & steady_in & uv_low & ~oc_ev; // [RULE_18]
  assign pg_bad = (v100 < pg_lo_lvl) | (v100 > pg_hi_lvl);
  assign fault_ev = oc_ev | uv_ev;
  assign fault_latch = (oc_ev & type_cfg_reg[`PPM_BIT_OVERCUR_LATCH]) |
    (uv_ev & type_cfg_reg[`PPM_BIT_UNDERV_LATCH]); // [RULE_02]
  // While the output is off it sits low anyway, so only the current limit can
  // still tell whether the cause of a trip has gone away.
  assign cond_gone = ~ilimit_in;
  assign tmr_done = tmr_reg >= RETRY_N;

  // Strobes and helpers shared by the processes below.
  assign st_wr = wr_hit(reg_wr_in, reg_addr_in, `PPM_ADDR_FLAGS);
  assign tmr_clear = ((state_reg == ST_RUN) & fault_ev) |
    ((state_reg == ST_RETRY) & tmr_done);
  assign latch_release = tmr_done & cond_gone & ((overcur_flag_reg & underv_flag_reg) |
    recycled_reg | (~en_d_reg & enable_cmd_in)); // [RULE_05]
  assign pg_blank = ~steady_in | ~conv_on_out;
  assign pg_window_bad = steady_in & conv_on_out & pg_bad;
  assign pg_ext_low = ~power_good_pin_pin_in & ~power_good_pin_oe_out;
  assign status_byte = {~temp_warn_out, ~pg_warn_out, 2'h3, overcur_flag_reg, underv_flag_reg, 2'h3};

  // Setting outputs drawn from the configuration registers. [RULE_16] [RULE_17]
  always @*
  begin
    cl_code_out = cl_sat(limit_cfg_reg[3:0]);
    temp_comp_out = limit_cfg_reg[`PPM_BIT_TEMP_COMP];
    load_slope_out = limit_cfg_reg[7:5];
    track_en_out = type_cfg_reg[`PPM_BIT_TRACK_EN];
  end

  // Configuration registers; writes land on the edge that sees the strobe.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      limit_cfg_reg <= `PPM_RST_LIMIT;
      level_cfg_reg <= `PPM_RST_LEVEL;
      type_cfg_reg <= `PPM_RST_TYPE;
    end
    else
    begin
      if (wr_hit(reg_wr_in, reg_addr_in, `PPM_ADDR_LIMIT))
        limit_cfg_reg <= reg_wdata_in; // [RULE_16] [RULE_17]
      // The top three level bits do not exist and always read zero.
      if (wr_hit(reg_wr_in, reg_addr_in, `PPM_ADDR_LEVEL))
        level_cfg_reg <= {3'h0, reg_wdata_in[4:0]};
      if (wr_hit(reg_wr_in, reg_addr_in, `PPM_ADDR_TYPE))
        type_cfg_reg <= reg_wdata_in; // [RULE_02]
    end
  end

  // Status flags, active low. Writing one clears a flag, but an event in the
  // same cycle wins, so that a fault landing on the clear is never lost. [RULE_21]
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      overcur_flag_reg <= 1'b1;
      underv_flag_reg <= 1'b1;
    end
    else
    begin
      if (oc_ev)
        overcur_flag_reg <= 1'b0; // [RULE_15]
      else if (st_wr && reg_wdata_in[`PPM_BIT_OVERCUR_FLAG])
        overcur_flag_reg <= 1'b1;
      if (uv_ev)
        underv_flag_reg <= 1'b0; // [RULE_18]
      else if (st_wr && reg_wdata_in[`PPM_BIT_UNDERV_FLAG])
        underv_flag_reg <= 1'b1;
    end
  end

  // Warnings only report; nothing in this process reaches the run request. [RULE_06]
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      temp_warn_out <= 1'b0;
      pg_warn_out <= 1'b0;
      power_good_pin_oe_out <= 1'b1;
    end
    else
    begin
      // Hysteresis keeps the warning from chattering at the trip point. [RULE_07]
      if (temp_in > `PPM_TEMP_WARN_ON)
        temp_warn_out <= 1'b1;
      else if (temp_in < `PPM_TEMP_WARN_OFF)
        temp_warn_out <= 1'b0; // [RULE_08]
      // The pin stays low while the output moves between levels. [RULE_10]
      power_good_pin_oe_out <= pg_blank | pg_window_bad; // [RULE_09]
      // A low pin that this block does not pull is an outside request. [RULE_12]
      pg_warn_out <= pg_window_bad | pg_ext_low; // [RULE_11]
    end
  end

  // Command history, used to see the turn-on command being cycled.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      en_d_reg <= 1'b0;
    else
      en_d_reg <= enable_cmd_in;
  end

  // Interval timer. It saturates rather than wraps, so that a long wait never
  // looks like a fresh start; a fault turn-off starts it again. [RULE_22]
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      tmr_reg <= 32'h0;
    else if (tmr_clear)
      tmr_reg <= 32'h0;
    else if (tmr_reg != 32'hFFFFFFFF)
      tmr_reg <= tmr_reg + 32'h1;
  end

  // Restart sequencer. The run request is a level; the ramp that follows it
  // belongs to the tracking and sequencing logic, not to this block.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= ST_RUN;
      conv_on_out <= 1'b0;
      fast_off_out <= 1'b0;
      recycled_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          conv_on_out <= enable_cmd_in;
          if (enable_cmd_in)
            fast_off_out <= 1'b0;
          recycled_reg <= 1'b0;
          if (fault_ev)
          begin
            conv_on_out <= 1'b0; // [RULE_13]
            fast_off_out <= oc_ev; // [RULE_15]
            if (fault_latch)
              state_reg <= ST_LATCH;
            else
              state_reg <= ST_RETRY;
          end
        end
        ST_RETRY:
        begin
          // Each interval the output is simply tried again; a cause that is
          // still there trips it again, which is how the retry repeats. [RULE_03]
          if (tmr_done)
          begin
            state_reg <= ST_RUN;
            conv_on_out <= enable_cmd_in; // [RULE_04]
            fast_off_out <= 1'b0;
          end
        end
        ST_LATCH:
        begin
          // A command cycled during the wait is remembered until the wait ends.
          if (!en_d_reg && enable_cmd_in)
            recycled_reg <= 1'b1;
          if (latch_release)
          begin
            state_reg <= ST_RUN;
            conv_on_out <= enable_cmd_in; // [RULE_05]
            fast_off_out <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_RUN;
          conv_on_out <= 1'b0;
        end
      endcase
    end
  end

  // Registered read answer; the status byte is built active low. [RULE_21]
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= 8'h00;
    else
    begin
      case (reg_addr_in)
        `PPM_ADDR_LIMIT: reg_rdata_out <= limit_cfg_reg;
        `PPM_ADDR_LEVEL: reg_rdata_out <= level_cfg_reg;
        `PPM_ADDR_TYPE: reg_rdata_out <= type_cfg_reg;
        default: reg_rdata_out <= status_byte;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- ppm_map.vh
// Purpose: Constants for the point-of-load protection manager.
// Assumes: Registers are reached through a plain register port; 8-bit data.
// Notes: Status bits are active low: a zero marks an active event.
// Operation
// RULE_01: Thresholds are percentages of the live setpoint.
// RULE_02: Per-protection latching choice and enable bits.
// RULE_03: Non-latching trip retries every 130 ms.
// RULE_04: Restart ramps per tracking and sequencing.
// RULE_05: Latched trip stays off until cleared.
// RULE_06: Warnings never turn the output off.
// RULE_07: Temperature above 120 C raises warning.
// RULE_08: Warning clears below 117 C only.
// RULE_09: Power-good window 110 percent, low 90/95.
// RULE_10: Power-good armed only in steady state.
// RULE_11: Power-good flag zero while warning active.
// RULE_12: External low on pin is warning.
// RULE_13: Any fault turns the output off.
// RULE_14: Overcurrent armed only above pre-bias voltage.
// RULE_15: Overcurrent plus undervoltage: fast turn-off.
// RULE_16: Current-limit code saturates at Bh.
// RULE_17: Software enable for temperature compensation.
// RULE_18: Undervoltage in steady state: regular turn-off.
// RULE_19: Overvoltage code 110, 120, 130 percent.
// RULE_20: Undervoltage code 75, 80, 85, 90 percent.
// RULE_21: Status bits read zero when active.
// RULE_22: Restart timer restarts at each fault turn-off.
`ifndef PPM_MAP_VH
`define PPM_MAP_VH
`define PPM_ADDR_LIMIT 2'h0
`define PPM_ADDR_LEVEL 2'h1
`define PPM_ADDR_TYPE 2'h2
`define PPM_ADDR_FLAGS 2'h3
`define PPM_RST_LIMIT 8'h1B
`define PPM_RST_LEVEL 8'h08
`define PPM_RST_TYPE 8'h41
`define PPM_CL_MAX 4'hB
`define PPM_BIT_TEMP_COMP 4
`define PPM_BIT_GOOD_LOW 4
`define PPM_BIT_TRACK_EN 7
`define PPM_BIT_OVERCUR_LATCH 3
`define PPM_BIT_UNDERV_LATCH 2
`define PPM_BIT_TEMP_FLAG 7
`define PPM_BIT_GOOD_FLAG 6
`define PPM_BIT_OVERCUR_FLAG 3
`define PPM_BIT_UNDERV_FLAG 2
`define PPM_RETRY_MS 130
`define PPM_CLK_MHZ 250
`define PPM_TEMP_WARN_ON 8'h78
`define PPM_TEMP_WARN_OFF 8'h75
`endif

//--- ppm_pg_wire.sv
// Purpose: Power-good wire with its pull-up and an outside puller.
// Assumes: The pin is open drain; nobody drives it high.
// Notes: A released wire rests high through the pull-up.
`timescale 1ns/1ps
`default_nettype none
module ppm_pg_wire (
  input wire logic oe_in, // Block pulls low.
  input wire logic ext_low_in, // Outside circuit pulls low.
  output logic pin_out // Wire level.
);
  // Any puller wins over the pull-up.
  assign pin_out = !(oe_in || ext_low_in);
endmodule
`default_nettype wire
